// file: rtl/plr_map.svh
/*
 map of register offsets, field positions, sizes and reset values for the
 partition label block; assumes byte addresses on an 8-bit decoded bus
*/
`ifndef PLR_MAP_SVH
`define PLR_MAP_SVH
`define PLR_ADDR_W 8
`define PLR_OFF_LBL 8'h00
`define PLR_OFF_VMAP 8'h20
`define PLR_OFF_CTRL 8'h40
`define PLR_OFF_MAXU 8'h44
`define PLR_OFF_STR0 8'h48
`define PLR_OFF_STR1 8'h4C
`define PLR_OFF_BITMAP0 8'h50
`define PLR_OFF_BITMAP1 8'h54
`define PLR_OFF_STAT 8'h58
`define PLR_CTRL_HYP 0
`define PLR_CTRL_VMAP 1
`define PLR_RST_CTRL 2'h0
`define PLR_BITMAP_WD 40
`define PLR_VPM_NUM 4
`define PLR_STRIDE_W 8
`define PLR_MAXU_MSB 15
`define PLR_MAXU_LSB 8
`define PLR_RESP_OKAY 2'h0
`define PLR_RESP_SLVERR 2'h2
`endif

// file: rtl/plr_pkg.sv
/*
 types shared by the partition label block: label fields, request and answer
 carriers and the block state; assumes plr_map.svh is on the include path
*/
`include "plr_map.svh"
package plr_pkg;
	typedef logic [15:0] plr_partid_t;
	typedef logic [7:0] plr_pmg_t;

	// one per-level label register
	typedef struct packed {
		plr_partid_t partid_i;
		plr_partid_t partid_d;
		plr_pmg_t pmg_i;
		plr_pmg_t pmg_d;
	} plr_label_s;

	typedef struct packed {
		logic valid;
		logic is_instruction_access;
		logic [1:0] level;
	} plr_req_s;

	typedef struct packed {
		logic valid;
		plr_partid_t partid;
		plr_pmg_t pmg;
	} plr_lbl_out_s;

	typedef struct packed {
		logic valid;
		logic [14:0] portion;
		logic [7:0] usage;
	} plr_alloc_req_s;

	// whole state of the block
	typedef struct packed {
		logic awready;
		logic wready;
		logic arready;
		logic bvalid;
		logic rvalid;
		logic [1:0] bresp;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic aw_have;
		logic w_have;
		logic [`PLR_ADDR_W-1:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		plr_label_s [3:0] lbl;
		logic [`PLR_VPM_NUM-1:0][63:0] vmap;
		logic [1:0] ctrl;
		logic [15:0] maxuse;
		logic [1:0][`PLR_STRIDE_W-1:0] stride;
		logic [`PLR_BITMAP_WD-1:0] portion_bitmap;
		plr_lbl_out_s lout;
		logic alloc_grant;
		logic alloc_deny;
		logic [1:0][15:0] deadline;
		logic [1:0] sched_gnt;
	} plr_st_s;
endpackage

// file: rtl/plr_top.sv
/*
 partition label selection, virtual identifier mapping and generic resource
 controls (portion bitmap, maximum usage, proportional stride) behind an
 AXI4-Lite slave; assumes one 100 MHz clock and requesters on that clock
*/
// The address map and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`include "plr_map.svh"

module plr_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [`PLR_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`PLR_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire plr_pkg::plr_req_s req,
	output plr_pkg::plr_lbl_out_s label_out,
	input wire plr_pkg::plr_alloc_req_s alloc_req,
	output logic alloc_grant,
	output logic alloc_deny,
	input wire logic [1:0] sched_req,
	output logic [1:0] sched_gnt
);
	plr_pkg::plr_st_s st_q;
	plr_pkg::plr_st_s st_d;

	// byte-lane merge for register writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// read decode, returns {error, data}
	function automatic logic [32:0] rd_word(input plr_pkg::plr_st_s s,
		input logic [`PLR_ADDR_W-1:0] a);
		logic [32:0] r;
		r = {1'b0, 32'h0000_0000};
		if (a < `PLR_OFF_VMAP) begin
			if (a[2]) begin
				r[31:0] = {16'h0000, s.lbl[a[4:3]].pmg_i, s.lbl[a[4:3]].pmg_d};
			end else begin
				r[31:0] = {s.lbl[a[4:3]].partid_i, s.lbl[a[4:3]].partid_d};
			end
		end else if (a < `PLR_OFF_CTRL) begin
			r[31:0] = s.vmap[a[4:3]][a[2]*32 +: 32];
		end else if (a[7:2] == `PLR_OFF_CTRL >> 2) begin
			r[31:0] = {30'h0000_0000, s.ctrl};
		end else if (a[7:2] == `PLR_OFF_MAXU >> 2) begin
			r[31:0] = {16'h0000, s.maxuse};
		end else if (a[7:2] == `PLR_OFF_STR0 >> 2) begin
			r[31:0] = {24'h00_0000, s.stride[0]};
		end else if (a[7:2] == `PLR_OFF_STR1 >> 2) begin
			r[31:0] = {24'h00_0000, s.stride[1]};
		end else if (a[7:2] == `PLR_OFF_BITMAP0 >> 2) begin
			r[31:0] = s.portion_bitmap[31:0];
		end else if (a[7:2] == `PLR_OFF_BITMAP1 >> 2) begin
			r[31:0] = {24'h00_0000, s.portion_bitmap[`PLR_BITMAP_WD-1:32]};
		end else if (a[7:2] == `PLR_OFF_STAT >> 2) begin
			r[31:0] = {8'h00, s.lout.pmg, s.lout.partid};
		end else begin
			r[32] = 1'b1;
		end
		return r;
	endfunction

	// next-state logic for bus, labels, allocation and scheduling
	always_comb begin
		logic [`PLR_ADDR_W-1:0] a;
		logic [32:0] rw;
		logic [31:0] m;
		plr_pkg::plr_label_s l;
		plr_pkg::plr_partid_t pid;
		plr_pkg::plr_pmg_t pg;
		logic [63:0] vw;
		logic ok_por;
		logic ok_use;
		logic [8:0] limit;
		logic [15:0] diff;
		logic pick1;
		a = st_q.awaddr;
		rw = {1'b0, 32'h0000_0000};
		m = 32'h0000_0000;
		l = st_q.lbl[req.level];
		pid = 16'h0000;
		pg = 8'h00;
		vw = 64'h0;
		ok_por = 1'b0;
		ok_use = 1'b0;
		limit = 9'h000;
		diff = 16'h0000;
		pick1 = 1'b0;
		st_d = st_q;

		// write address and data are taken independently
		if (st_q.awready && s_axi_awvalid) begin
			st_d.aw_have = 1'b1;
			st_d.awaddr = s_axi_awaddr;
		end
		if (st_q.wready && s_axi_wvalid) begin
			st_d.w_have = 1'b1;
			st_d.wdata = s_axi_wdata;
			st_d.wstrb = s_axi_wstrb;
		end
		if (st_q.bvalid && s_axi_bready) begin
			st_d.bvalid = 1'b0;
		end

		// register write once both halves are held and no response pends
		if (st_q.aw_have && st_q.w_have && !st_q.bvalid) begin
			rw = rd_word(st_q, a);
			m = merge(rw[31:0], st_q.wdata, st_q.wstrb);
			st_d.bresp = `PLR_RESP_OKAY;
			if (a < `PLR_OFF_VMAP) begin
				if (a[2]) begin
					st_d.lbl[a[4:3]].pmg_i = m[15:8];
					st_d.lbl[a[4:3]].pmg_d = m[7:0];
				end else begin
					st_d.lbl[a[4:3]].partid_i = m[31:16];
					st_d.lbl[a[4:3]].partid_d = m[15:0];
				end
			end else if (a < `PLR_OFF_CTRL) begin
				st_d.vmap[a[4:3]][a[2]*32 +: 32] = m;
			end else if (a[7:2] == `PLR_OFF_CTRL >> 2) begin
				st_d.ctrl = m[1:0];
			end else if (a[7:2] == `PLR_OFF_MAXU >> 2) begin
				st_d.maxuse = m[15:0];
			end else if (a[7:2] == `PLR_OFF_STR0 >> 2) begin
				st_d.stride[0] = m[`PLR_STRIDE_W-1:0];
			end else if (a[7:2] == `PLR_OFF_STR1 >> 2) begin
				st_d.stride[1] = m[`PLR_STRIDE_W-1:0];
			end else if (a[7:2] == `PLR_OFF_BITMAP0 >> 2) begin
				st_d.portion_bitmap[31:0] = m;
			end else if (a[7:2] == `PLR_OFF_BITMAP1 >> 2) begin
				st_d.portion_bitmap[`PLR_BITMAP_WD-1:32] = m[`PLR_BITMAP_WD-33:0];
			end else if (rw[32]) begin
				st_d.bresp = `PLR_RESP_SLVERR;
			end
			st_d.aw_have = 1'b0;
			st_d.w_have = 1'b0;
			st_d.bvalid = 1'b1;
		end
		st_d.awready = !st_d.aw_have;
		st_d.wready = !st_d.w_have;

		// read answered one cycle after the address is taken
		if (st_q.rvalid && s_axi_rready) begin
			st_d.rvalid = 1'b0;
		end
		if (st_q.arready && s_axi_arvalid) begin
			rw = rd_word(st_q, s_axi_araddr);
			st_d.rdata = rw[31:0];
			st_d.rresp = rw[32] ? `PLR_RESP_SLVERR : `PLR_RESP_OKAY;
			st_d.rvalid = 1'b1;
		end
		st_d.arready = !st_d.rvalid;

		// label select by level and access side
		pid = req.is_instruction_access ? l.partid_i : l.partid_d;
		pg = req.is_instruction_access ? l.pmg_i : l.pmg_d;
		if (req.level == 2'h2 && !st_q.ctrl[`PLR_CTRL_HYP]) begin
			pid = 16'h0000;
			pg = 8'h00;
		end
		// virtual mapping at levels 0 and 1
		if (st_q.ctrl[`PLR_CTRL_VMAP] && st_q.ctrl[`PLR_CTRL_HYP] && !req.level[1]) begin
			if (pid[15:2] < 14'(`PLR_VPM_NUM)) begin
				vw = st_q.vmap[pid[3:2]];
			end
			pid = vw[{pid[1:0], 4'h0} +: 16];
		end
		st_d.lout.valid = req.valid;
		st_d.lout.partid = pid;
		st_d.lout.pmg = pg;

		// portion bitmap and maximum-usage checks
		if (alloc_req.portion < 15'(`PLR_BITMAP_WD)) begin
			ok_por = st_q.portion_bitmap[alloc_req.portion[5:0]];
		end
		limit = {1'b0, st_q.maxuse[`PLR_MAXU_MSB:`PLR_MAXU_LSB]} + 9'h001;
		ok_use = {1'b0, alloc_req.usage} < limit;
		st_d.alloc_grant = alloc_req.valid && ok_por && ok_use;
		st_d.alloc_deny = alloc_req.valid && !(ok_por && ok_use);

		// earliest-deadline stride scheduler, work conserving
		diff = st_q.deadline[1] - st_q.deadline[0];
		pick1 = sched_req[1] && (!sched_req[0] || diff[15]);
		st_d.sched_gnt = 2'h0;
		if (sched_req != 2'h0) begin
			st_d.sched_gnt = pick1 ? 2'h2 : 2'h1;
			st_d.deadline[pick1] = st_q.deadline[pick1] +
				{8'h00, st_q.stride[pick1]} + 16'h0001;
		end
		// an idle class banks no credit
		if (!sched_req[0]) begin
			st_d.deadline[0] = st_d.deadline[1];
		end
		if (!sched_req[1]) begin
			st_d.deadline[1] = st_d.deadline[0];
		end
	end

	// state register, synchronous reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// outputs straight from state
	assign s_axi_awready = st_q.awready;
	assign s_axi_wready = st_q.wready;
	assign s_axi_bresp = st_q.bresp;
	assign s_axi_bvalid = st_q.bvalid;
	assign s_axi_arready = st_q.arready;
	assign s_axi_rdata = st_q.rdata;
	assign s_axi_rresp = st_q.rresp;
	assign s_axi_rvalid = st_q.rvalid;
	assign label_out = st_q.lout;
	assign alloc_grant = st_q.alloc_grant;
	assign alloc_deny = st_q.alloc_deny;
	assign sched_gnt = st_q.sched_gnt;

	// helpers read only by the checks
	logic [15:0] vm1_f1;
	logic [15:0] dl0;
	logic [7:0] st0;
	assign vm1_f1 = st_q.vmap[1][31:16];
	assign dl0 = st_q.deadline[0];
	assign st0 = st_q.stride[0];

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_l2_gate: assert property (
		req.valid && req.level == 2'h2 && !st_q.ctrl[`PLR_CTRL_HYP]
		|=> label_out.valid && label_out.partid == 16'h0000 && label_out.pmg == 8'h00)
		else $error("level 2 label not zero with hypervisor off");
	chk_instr_side: assert property (
		req.valid && req.level == 2'h3 && req.is_instruction_access
		|=> label_out.partid == $past(st_q.lbl[3].partid_i))
		else $error("instruction side identifier not taken");
	chk_group_data: assert property (
		req.valid && req.level == 2'h3 && !req.is_instruction_access
		|=> label_out.pmg == $past(st_q.lbl[3].pmg_d))
		else $error("data side group not taken");
	chk_level0_reg: assert property (
		req.valid && req.level == 2'h0 && !st_q.ctrl[`PLR_CTRL_VMAP]
		&& !req.is_instruction_access
		|=> label_out.partid == $past(st_q.lbl[0].partid_d))
		else $error("level 0 register not used");
	chk_map_range: assert property (
		req.level == 2'h1 && !req.is_instruction_access && st_q.ctrl == 2'h3
		&& st_q.lbl[1].partid_d[15:2] >= 14'h0004
		|=> label_out.partid == 16'h0000)
		else $error("out of range map word not zero");
	chk_map_field: assert property (
		req.level == 2'h1 && !req.is_instruction_access && st_q.ctrl == 2'h3
		&& st_q.lbl[1].partid_d == 16'h0005
		|=> label_out.partid == $past(vm1_f1))
		else $error("wrong map field selected");
	chk_portion_off: assert property (
		alloc_req.valid && alloc_req.portion >= 15'h0028 |=> alloc_deny && !alloc_grant)
		else $error("portion beyond bitmap granted");
	chk_usage_cap: assert property (
		alloc_req.valid && alloc_req.usage > st_q.maxuse[15:8] |=> !alloc_grant)
		else $error("allocation past usage limit");
	chk_bitmap_top: assert property (
		s_axi_arvalid && s_axi_arready && s_axi_araddr == `PLR_OFF_BITMAP1
		|=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h00_0000)
		else $error("unused bitmap bits not zero");
	chk_work_cons: assert property (
		sched_req != 2'h0 |=> $onehot(sched_gnt))
		else $error("scheduler idle with requests");
	chk_stride_step: assert property (
		sched_req == 2'h1 ##1 sched_req == 2'h1
		|-> dl0 == $past(dl0) + {8'h00, $past(st0)} + 16'h0001)
		else $error("deadline step not stride plus one");

	cov_l2_label: cover property (req.valid && req.level == 2'h2 ##1 label_out.valid);
	cov_alloc_ok: cover property (alloc_req.valid ##1 alloc_grant);
	cov_sched_both: cover property (sched_req == 2'h3 ##1 sched_gnt == 2'h2);
endmodule

// file: sim/plr_far_model.sv
/*
 far-side requester model: turns bench commands into label and allocation
 requests; assumes commands change by non-blocking assignment after a rising edge
*/
`timescale 1ns/1ps
module plr_far_model (
	input wire logic aclk,
	input wire logic go,
	input wire logic [1:0] lvl,
	input wire logic is_instr,
	input wire logic ago,
	input wire logic [14:0] portion,
	input wire logic [7:0] usage,
	output plr_pkg::plr_req_s req,
	output plr_pkg::plr_alloc_req_s alloc_req
);
	// one-cycle request pulses, fields follow the command lines
	always @(posedge aclk) begin
		req <= '{go, is_instr, lvl};
		alloc_req <= '{ago, portion, usage};
	end
endmodule

// file: sim/tb_top.sv
/*
 self-checking bench for the partition label block: bus setup, label rows,
 allocation rows, scheduler share; assumes one 100 MHz clock for all parts
*/
`timescale 1ns/1ps
module tb_top;
	typedef struct packed {
		logic [1:0] ctrl;
		logic [1:0] lvl;
		logic is_instr;
		logic [15:0] pid;
		logic [7:0] pmg;
	} plr_row_s;
	typedef struct packed {
		logic [15:0] maxu;
		logic [14:0] portion;
		logic [7:0] usage;
		logic g;
	} plr_arow_s;
	plr_row_s rows [16] = '{
		'{2'h0, 2'h2, 1'h0, 16'h0000, 8'h00}, '{2'h0, 2'h2, 1'h1, 16'h0000, 8'h00},
		'{2'h0, 2'h3, 1'h1, 16'h3333, 8'h33}, '{2'h0, 2'h3, 1'h0, 16'h3003, 8'h34},
		'{2'h0, 2'h1, 1'h1, 16'h0011, 8'h31}, '{2'h0, 2'h1, 1'h0, 16'h000E, 8'h13},
		'{2'h0, 2'h0, 1'h1, 16'h0006, 8'h30}, '{2'h0, 2'h0, 1'h0, 16'h0001, 8'h03},
		'{2'h1, 2'h2, 1'h1, 16'h2222, 8'h32}, '{2'h1, 2'h2, 1'h0, 16'h2002, 8'h23},
		'{2'h3, 2'h0, 1'h1, 16'h8012, 8'h30}, '{2'h3, 2'h0, 1'h0, 16'h8001, 8'h03},
		'{2'h3, 2'h1, 1'h1, 16'h0000, 8'h31}, '{2'h3, 2'h1, 1'h0, 16'h8032, 8'h13},
		'{2'h3, 2'h3, 1'h0, 16'h3003, 8'h34}, '{2'h3, 2'h2, 1'h0, 16'h2002, 8'h23}};
	plr_arow_s arows [11] = '{
		'{16'h3F00, 15'h0000, 8'h00, 1'h1}, '{16'h3F00, 15'h001F, 8'h00, 1'h1},
		'{16'h3F00, 15'h0001, 8'h00, 1'h0}, '{16'h3F00, 15'h0027, 8'h00, 1'h1},
		'{16'h3F00, 15'h0026, 8'h00, 1'h0}, '{16'h3F00, 15'h0028, 8'h00, 1'h0},
		'{16'h3F00, 15'h0000, 8'h3F, 1'h1}, '{16'h3F00, 15'h0000, 8'h40, 1'h0},
		'{16'hFFFF, 15'h0027, 8'hFF, 1'h1}, '{16'h00FF, 15'h0000, 8'h00, 1'h1},
		'{16'h00FF, 15'h0000, 8'h01, 1'h0}};
	logic [31:0] pidw [4] = '{32'h0006_0001, 32'h0011_000E, 32'h2222_2002, 32'h3333_3003};
	logic [31:0] pmgw [4] = '{32'h3003, 32'h3113, 32'h3223, 32'h3334};
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hF;
	logic awready, wready, bvalid, arready, rvalid, alloc_grant, alloc_deny;
	logic [1:0] bresp, rresp, sched_gnt;
	logic [31:0] rdata;
	logic go = 1'h0, is_instr = 1'h0, ago = 1'h0;
	logic [1:0] lvl = 2'h0, sched_req = 2'h0, last_ctrl;
	logic [14:0] portion = 15'h0;
	logic [7:0] usage = 8'h0;
	logic [15:0] last_maxu;
	logic [31:0] pbw [2];
	plr_pkg::plr_req_s req;
	plr_pkg::plr_lbl_out_s label_out;
	plr_pkg::plr_alloc_req_s alloc_req;
	int error_cnt = 0, n_compared = 0, cyc = 0, c0 = 0, c1 = 0;

	plr_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .req(req), .label_out(label_out), .alloc_req(alloc_req),
		.alloc_grant(alloc_grant), .alloc_deny(alloc_deny), .sched_req(sched_req),
		.sched_gnt(sched_gnt));
	plr_far_model i_far (.aclk(aclk), .go(go), .lvl(lvl), .is_instr(is_instr), .ago(ago),
		.portion(portion), .usage(usage), .req(req), .alloc_req(alloc_req));

	// free-running clock, 10 ns period
	always #5 aclk = ~aclk;

	// hang guard
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			test_done();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic test_done();
		if (error_cnt == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// bus write: address and data offered together, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'h0;
			if (wvalid && wready) wvalid <= 1'h0;
		end while (bvalid !== 1'h1);
		bready <= 1'h0;
		chk({30'h0, bresp}, {30'h0, er});
	endtask

	// bus read and compare of data and response
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'h0;
		end while (rvalid !== 1'h1);
		rready <= 1'h0;
		chk(rdata, e);
		chk({30'h0, rresp}, {30'h0, er});
	endtask

	// one request pulse through the far model, then settle after the answer edge
	task automatic fire(input logic [1:0] l, input logic i, input logic [14:0] p,
		input logic [7:0] u, input logic a);
		@(posedge aclk);
		lvl <= l;
		is_instr <= i;
		portion <= p;
		usage <= u;
		go <= !a;
		ago <= a;
		@(posedge aclk);
		go <= 1'h0;
		ago <= 1'h0;
		@(posedge aclk);
		@(negedge aclk);
	endtask

	// oversized strides saturate at the top field value
	function automatic logic [7:0] stride_field(input int s);
		return (s > 256) ? 8'hFF : 8'(s - 1);
	endfunction

	// main sequence
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'h1;
		rdchk(8'h40, 32'h0, 2'h0);
		rdchk(8'h50, 32'h0, 2'h0);
		rdchk(8'hFC, 32'h0, 2'h2);
		wr(8'hF0, 32'h1, 2'h2);
		wr(8'h54, 32'hFFFF_FFFF, 2'h0);
		rdchk(8'h54, 32'h0000_00FF, 2'h0);
		for (int l = 0; l < 4; l++) begin
			wr(8'(8 * l), pidw[l], 2'h0);
			wr(8'(8 * l + 4), pmgw[l], 2'h0);
			wr(8'(8 * l + 32), {16'(16'h8001 + 16 * l), 16'(16'h8000 + 16 * l)}, 2'h0);
			wr(8'(8 * l + 36), {16'(16'h8003 + 16 * l), 16'(16'h8002 + 16 * l)}, 2'h0);
		end
		last_ctrl = 2'h3;
		foreach (rows[i]) begin
			if (rows[i].ctrl !== last_ctrl) wr(8'h40, {30'h0, rows[i].ctrl}, 2'h0);
			last_ctrl = rows[i].ctrl;
			fire(rows[i].lvl, rows[i].is_instr, 15'h0, 8'h0, 1'h0);
			chk({7'h00, label_out.valid, label_out.partid, label_out.pmg},
				{8'h01, rows[i].pid, rows[i].pmg});
		end
		// mapping still on: id 5 hits word 1 slot 1, id 0x10 is past the last word
		wr(8'h08, 32'h0011_0005, 2'h0);
		fire(2'h1, 1'h0, 15'h0, 8'h0, 1'h0);
		chk({16'h0, label_out.partid}, 32'h0000_8011);
		wr(8'h08, 32'h0011_0010, 2'h0);
		fire(2'h1, 1'h0, 15'h0, 8'h0, 1'h0);
		chk({16'h0, label_out.partid}, 32'h0000_0000);
		pbw = '{32'h0, 32'h0};
		foreach (pbw[k]) begin
			for (int n = 0; n < 40; n++) begin
				if ((n == 0 || n == 31 || n == 39) && ((n >> 3) & ~3) == 4 * k) pbw[k][n & 31] = 1'h1;
			end
		end
		wr(8'h50, pbw[0], 2'h0);
		wr(8'h54, pbw[1], 2'h0);
		last_maxu = 16'h0;
		foreach (arows[i]) begin
			if (arows[i].maxu !== last_maxu) wr(8'h44, {16'h0, arows[i].maxu}, 2'h0);
			last_maxu = arows[i].maxu;
			fire(2'h0, 1'h0, arows[i].portion, arows[i].usage, 1'h1);
			chk({30'h0, alloc_grant, alloc_deny},
				{30'h0, arows[i].g, !arows[i].g});
		end
		wr(8'h48, {24'h0, stride_field(1)}, 2'h0);
		wr(8'h4C, {24'h0, stride_field(3)}, 2'h0);
		@(posedge aclk);
		sched_req <= 2'h3;
		@(posedge aclk);
		repeat (8) begin
			@(negedge aclk);
			c0 += int'(sched_gnt[0] === 1'h1);
			c1 += int'(sched_gnt[1] === 1'h1);
		end
		chk(c0, 6);
		chk(c1, 2);
		@(posedge aclk);
		sched_req <= 2'h2;
		@(posedge aclk);
		@(negedge aclk);
		chk({30'h0, sched_gnt}, 32'h2);
		// class 0 alone for two cycles steps its deadline by its stride
		@(posedge aclk);
		sched_req <= 2'h1;
		@(posedge aclk);
		@(negedge aclk);
		chk({30'h0, sched_gnt}, 32'h1);
		@(posedge aclk);
		sched_req <= 2'h0;
		aresetn <= 1'h0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		rdchk(8'h40, 32'h0, 2'h0);
		rdchk(8'h44, 32'h0, 2'h0);
		// byte strobes: only lane 1 of the usage limit may change
		wstrb <= 4'h2;
		wr(8'h44, 32'hFFFF_FFFF, 2'h0);
		wstrb <= 4'hF;
		rdchk(8'h44, 32'h0000_FF00, 2'h0);
		test_done();
	end
endmodule
